// File: bank4_regs.vh
`ifndef BANK4_REGS_VH
`define BANK4_REGS_VH
// register byte addresses
`define B4_STATUS_LO_ADDR 4'h0
`define B4_STATUS_HI_ADDR 4'h4
`define B4_MISC_ADDR 4'h8
`define B4_CTRL_ADDR 4'hC
// status word field positions
`define B4_VAL_BIT 63
`define B4_UC_BIT 61
`define B4_MISC_VALID_FLAG_BIT 59
`define B4_THR_HI 54
`define B4_THR_LO 53
`define B4_SYNV_BIT 52
`define B4_SYN_HI 51
`define B4_SYN_LO 44
`define B4_FMT_HI 41
`define B4_FMT_LO 40
`define B4_CNT_HI 39
`define B4_CNT_LO 32
`define B4_MSEC_HI 31
`define B4_MSEC_LO 16
// type a fixed pattern in bits 31:21
`define B4_TYPEA_FIXED 11'h100
// type b one-hot bits, relative to bit 16
`define B4_TYPEB_ECC_IDX 9
`define B4_TYPEB_MASK 16'h0FF7
// error types
`define B4_TYPE_A 2'h0
`define B4_TYPE_B 2'h1
`define B4_TYPE_C 2'h2
// threshold codes and counter limit
`define B4_THR_NONE 2'h0
`define B4_THR_GREEN 2'h1
`define B4_THR_YELLOW 2'h2
`define B4_CNT_MAX 8'hFF
`endif

// File: bank4_misc_mem.v
`timescale 1ns/10ps
// small store for the misc information word, registered read
module bank4_misc_mem #(
    parameter WIDTH = 32
) (
    input wire clk_i,
    input wire rst_i,
    input wire we_i,
    input wire [WIDTH-1:0] wdata_i,
    output reg [WIDTH-1:0] rdata_o
);
    reg [WIDTH-1:0] store_r;

    // one word, read data registered for a clean bus return
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            store_r <= {WIDTH{1'b0}};
            rdata_o <= {WIDTH{1'b0}};
        end
        else
        begin
            if (we_i)
                store_r <= wdata_i;
            rdata_o <= we_i ? wdata_i : store_r;
        end
    end
endmodule // bank4_misc_mem

// File: bank4_error_status_encoder.v
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "bank4_regs.vh"
// Contract
// - bits 56:32 use one layout for error types A, B and C.
// - 8-bit correctable count, cleared by cold reset only, saturates 255.
// - bits 41:40 give misc register format, valid with misc-valid flag.
// - syndrome sits in bits 51:44 when syndrome-valid is set.
// - bit 52 set only when a correctable ECC event supplies syndrome.
// - bits 54:53 threshold: none, green, yellow; 11 reserved.
// - threshold meaningful only with valid; undefined when uncorrected.
// - type A code in 18:16, 20:19 zero, 31:21 fixed pattern.
// - type A codes 001..111 name multi-way or single-way outcomes.
// - type B bits 16,17,18 flag request and address parity errors.
// - type B bits 20..23 flag response and data parity errors.
// - type B bit 24 defer parity, bit 25 inbound data ECC.
// - type B bits 26 and 27 flag data and request strobe glitches.
// - a logged type B code has exactly one defined bit set.
// - only inbound data ECC may be correctable; other type B uncorrected.
// - uncorrected flag bit 61 set when not corrected, else clear.
// - misc-valid bit 59 set only when misc register holds information.
// - valid bit 63 set on logging; software clears it.
module bank4_error_status_encoder #(
    parameter MISC_WIDTH = 32
) (
    input wire clk_i,
    input wire rst_i,
    input wire cold_rst_i,
    // error log request from the detectors
    input wire log_i,
    input wire [1:0] err_type_i,
    input wire [15:0] mca_code_i,
    input wire [2:0] typea_code_i,
    input wire [15:0] typeb_bits_i,
    input wire [15:0] typec_code_i,
    input wire uncorrected_i,
    input wire syn_supplied_i,
    input wire [7:0] syndrome_i,
    input wire [1:0] threshold_i,
    input wire misc_supplied_i,
    input wire [1:0] misc_format_i,
    input wire [MISC_WIDTH-1:0] misc_data_i,
    // classic wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg valid_o,
    output reg log_reject_o
);
    reg [63:0] status_r;
    reg [7:0] count_r;
    reg log_en_r;
    reg [15:0] msec_nxt;
    reg uc_nxt;
    reg ok_nxt;
    wire [MISC_WIDTH-1:0] misc_rd;
    wire bus_req;
    wire wr_hi;
    wire misc_we;

    // true when exactly one bit of a vector is set
    function onehot16;
        input [15:0] v;
        begin
            onehot16 = (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
        end
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_hi = bus_req && wb_we_i && (wb_adr_i == `B4_STATUS_HI_ADDR);
    // misc only loads when a log will really carry misc information
    assign misc_we = log_i && ok_nxt && misc_supplied_i;

    // type-specific code and correction class
    always @*
    begin
        msec_nxt = 16'h0000;
        uc_nxt = uncorrected_i;
        ok_nxt = log_en_r;
        case (err_type_i)
            `B4_TYPE_A:
            begin
                // 20:19 stay zero, 31:21 fixed
                msec_nxt = {`B4_TYPEA_FIXED, 2'b00, typea_code_i};
                // codes 001..111 are passed as the detector encodes them
                msec_nxt[2:0] = typea_code_i;
            end
            `B4_TYPE_B:
            begin
                // keep only defined bits; reserved 19 and 31:28 are zero
                msec_nxt = typeb_bits_i & `B4_TYPEB_MASK;
                // bits 20..27 carry parity, defer, ecc and glitch flags
                msec_nxt[11:4] = typeb_bits_i[11:4];
                // a code that is not one-hot is refused
                if (!onehot16(typeb_bits_i & `B4_TYPEB_MASK) ||
                    (typeb_bits_i & ~`B4_TYPEB_MASK) != 16'h0000)
                    ok_nxt = 1'b0;
                // only the inbound ecc bit may be correctable
                if (!typeb_bits_i[`B4_TYPEB_ECC_IDX])
                    uc_nxt = 1'b1;
            end
            `B4_TYPE_C:
                msec_nxt = typec_code_i;
            default:
                ok_nxt = 1'b0;
        endcase
        // the shared field is built below independent of the type
    end

    // correctable event counter, only cold reset clears it
    always @(posedge clk_i)
    begin
        if (cold_rst_i)
            count_r <= 8'h00;
        else if (log_i && ok_nxt && !uc_nxt && count_r != `B4_CNT_MAX)
            count_r <= count_r + 8'h01;
    end

    // status word; a log in the same cycle as a software clear wins
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_r <= 64'h0000_0000_0000_0000;
            log_en_r <= 1'b1;
            log_reject_o <= 1'b0;
        end
        else
        begin
            log_reject_o <= log_i && !ok_nxt;
            if (bus_req && wb_we_i && wb_adr_i == `B4_CTRL_ADDR && wb_sel_i[0])
                log_en_r <= wb_dat_i[0];
            // software may clear the valid flag through the high word
            if (wr_hi && wb_sel_i[3] && !wb_dat_i[31])
                status_r[`B4_VAL_BIT] <= 1'b0;
            if (log_i && ok_nxt)
            begin
                status_r[15:0] <= mca_code_i;
                status_r[`B4_MSEC_HI:`B4_MSEC_LO] <= msec_nxt;
                // same layout for every type
                status_r[56:55] <= 2'b00;
                status_r[43:42] <= 2'b00;
                // threshold undefined under uncorrected: report none
                status_r[`B4_THR_HI:`B4_THR_LO] <=
                    uc_nxt ? `B4_THR_NONE : threshold_i;
                status_r[`B4_SYNV_BIT] <=
                    !uc_nxt && syn_supplied_i;
                status_r[`B4_SYN_HI:`B4_SYN_LO] <=
                    (!uc_nxt && syn_supplied_i) ? syndrome_i : 8'h00;
                status_r[`B4_FMT_HI:`B4_FMT_LO] <=
                    misc_supplied_i ? misc_format_i : 2'b00;
                status_r[62] <= status_r[`B4_VAL_BIT];
                status_r[`B4_UC_BIT] <= uc_nxt;
                status_r[60] <= 1'b0;
                status_r[`B4_MISC_VALID_FLAG_BIT] <= misc_supplied_i;
                status_r[58] <= 1'b0;
                status_r[57] <= uc_nxt;
                status_r[`B4_VAL_BIT] <= 1'b1;
            end
        end
    end

    bank4_misc_mem #(
        .WIDTH(MISC_WIDTH)
    ) u_misc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(misc_we),
        .wdata_i(misc_data_i),
        .rdata_o(misc_rd)
    );

    // one-wait-state slave: ack one cycle after the request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            valid_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            valid_o <= status_r[`B4_VAL_BIT];
            case (wb_adr_i)
                `B4_STATUS_LO_ADDR:
                    wb_dat_o <= status_r[31:0];
                `B4_STATUS_HI_ADDR:
                    // live counter mirrored into 39:32
                    wb_dat_o <= {status_r[63:40], count_r};
                `B4_MISC_ADDR:
                    wb_dat_o <= misc_rd;
                `B4_CTRL_ADDR:
                    wb_dat_o <= {31'h0000_0000, log_en_r};
                default:
                    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // bank4_error_status_encoder

// File: enc_chk_sva.sv
`timescale 1ns/10ps
// watches the bus answer, the log refusal pulse and the valid level
module enc_chk (
    input wire clk_i,
    input wire rst_i,
    input wire log_i,
    input wire [1:0] err_type_i,
    input wire [15:0] typeb_bits_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire valid_o,
    input wire log_reject_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a taken request is answered next cycle, and only for one cycle
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pls; wb_ack_o |=> !wb_ack_o; endproperty
    a_pls: assert property (p_pls) else $error("ack too long");
    // type 3 and any non one-hot type b code are refused
    property p_rej3; log_i && err_type_i == 2'h3 |=> log_reject_o; endproperty
    a_rej3: assert property (p_rej3) else $error("type 3 taken");
    property p_rejb;
        log_i && err_type_i == 2'h1 && $countones(typeb_bits_i) != 1
        |=> log_reject_o;
    endproperty
    a_rejb: assert property (p_rejb) else $error("bad code taken");
    property p_rsrc; log_reject_o |-> $past(log_i); endproperty
    a_rsrc: assert property (p_rsrc) else $error("stray refusal");
    // an accepted log shows valid two cycles on; only the bus clears it
    property p_val; log_i ##1 !log_reject_o |=> valid_o; endproperty
    a_val: assert property (p_val) else $error("valid not set");
    property p_hold; (valid_o && !wb_cyc_i) [*3] |=> valid_o; endproperty
    a_hold: assert property (p_hold) else $error("valid lost");
    property p_rst; $fell(rst_i) |-> !valid_o && !wb_ack_o; endproperty
    a_rst: assert property (p_rst) else $error("reset leak");
endmodule // enc_chk

bind bank4_error_status_encoder enc_chk u_chk (.*);

// File: tb.sv
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            mismatches++; \
            $display("mismatch at %0t: %h vs %h", $time, a, b); \
        end \
    end
module tb;
    logic clk_i = 0, rst_i = 1, cold_rst_i = 1, log_i = 0, val = 0, ue;
    logic uncorrected_i = 0, syn_supplied_i = 0, misc_supplied_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, valid_o;
    logic log_reject_o;
    logic [1:0] err_type_i = '0, threshold_i = '0, misc_format_i = '0;
    logic [2:0] typea_code_i = '0;
    logic [3:0] wb_adr_i = '0, wb_sel_i = 4'hF;
    logic [7:0] syndrome_i = '0, cnt = '0;
    logic [15:0] mca_code_i = '0, typeb_bits_i = '0, typec_code_i = '0, i;
    logic [31:0] misc_data_i = '0, wb_dat_i = '0, wb_dat_o, lo, hi, mk, r;
    logic [31:0] md = '0;
    logic [63:0] e, exp_q[$];
    int seed = 32'hD834, mismatches = 0, comparisons = 0;
    bank4_error_status_encoder u_dut (.*);
    always #50 clk_i = ~clk_i;
    // one classic cycle; a read leaves {mask, data} for the monitor
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, m);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        if (!w) exp_q.push_back({m, d & m});
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // read data is judged at the ack edge, oldest note first
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && !wb_we_i)
        begin
            e = exp_q.pop_front();
            `CHK(wb_dat_o & e[63:32], e[31:0])
        end
    end
    // one log pulse; the model only moves when the log must be taken
    task lg(input logic [1:0] t, input logic [15:0] c, input logic u, s, bad);
        r = $random(seed);
        @(posedge clk_i);
        {log_i, err_type_i, uncorrected_i, syn_supplied_i} <= {1'b1, t, u, s};
        {typea_code_i, typeb_bits_i, typec_code_i} <= {c[2:0], c, c};
        {mca_code_i, syndrome_i, misc_data_i} <= {r[31:16], r[7:0], r};
        {misc_supplied_i, misc_format_i} <= r[12:10];
        threshold_i <= {r[9], r[8] & ~r[9]};
        ue = u | (t == 2'h1 && c != 16'h0200);
        if (!bad)
        begin
            lo = {t == 2'h0 ? {11'h100, 2'b00, c[2:0]} : c, r[31:16]};
            hi = {1'b1, val, ue, 1'b0, r[12], 1'b0, ue, 2'b00,
                ue ? 2'b00 : {r[9], r[8] & ~r[9]}, s & !ue,
                (s & !ue) ? r[7:0] : 8'h00, 2'b00, r[11:10], 8'h00};
            mk = r[12] ? '1 : 32'hFFFFFCFF;
            md = r[12] ? r : md;
            cnt = (ue || cnt == 8'hFF) ? cnt : cnt + 8'h01;
            val = 1'b1;
        end
        @(posedge clk_i);
        log_i <= 1'b0;
        #1 `CHK(log_reject_o, bad)
    endtask
    // both halves of the status word, count shown live
    task chk;
        bus(1'b0, 4'h0, lo, '1);
        bus(1'b0, 4'h4, {hi[31:8], cnt}, mk);
        bus(1'b0, 4'h8, md, '1);
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        {rst_i, cold_rst_i} <= 2'b00;
        bus(1'b0, 4'hC, 32'h1, 32'h1);
        for (i = 0; i < 8; i++)
        begin
            r = $random(seed);
            lg(2'h0, i, r[0], r[1], 1'b0);
            chk;
        end
        $display("type a codes done");
        for (i = 0; i < 12; i++)
            if (i != 3)
            begin
                r = $random(seed);
                lg(2'h1, 16'h1 << i, r[0], r[1], 1'b0);
                chk;
            end
        $display("type b bits done");
        lg(2'h2, 16'hC001, 1'b0, 1'b1, 1'b0);
        chk;
        lg(2'h3, '0, 1'b0, 1'b0, 1'b1);
        lg(2'h1, 16'h0003, 1'b0, 1'b0, 1'b1);
        lg(2'h1, '0, 1'b0, 1'b0, 1'b1);
        bus(1'b1, 4'hC, '0, '0);
        lg(2'h0, 16'h5, 1'b0, 1'b0, 1'b1);
        bus(1'b1, 4'hC, 32'h1, '0);
        bus(1'b0, 4'h2, '0, '1);
        chk;
        $display("refusals done");
        bus(1'b1, 4'h4, '0, '0);
        {hi[31], val} = 2'b00;
        chk;
        repeat (260) lg(2'h0, 16'h5, 1'b0, 1'b0, 1'b0);
        chk;
        @(posedge clk_i) cold_rst_i <= 1'b1;
        @(posedge clk_i) cold_rst_i <= 1'b0;
        cnt = '0;
        chk;
        $display("counter done");
        end_of_test;
    end
    // cuts a hang short; the run needs about a sixth of this
    initial
    begin
        #500000;
        mismatches++;
        end_of_test;
    end
    task end_of_test;
        $display("%0d mismatches, %0d comparisons", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
endmodule // tb
